// [hdl/lcp_cond.sv]
module lcp_cond (
   input  wire lcp_pkg::lcp_cfg_t              cfg,
   input  wire logic [lcp_pkg::LCP_IN_W-1:0]   in_bus,
   input  wire logic [3:0]                     gate_raw,
   input  wire logic                           logic_raw,
   output      lcp_pkg::lcp_cond_t             cond
);
   import lcp_pkg::*;

   assign cond.gates     = gate_raw ^ cfg.gate_inv;
   assign cond.final_out = logic_raw ^ cfg.out_inv;
   assign cond.d2        = lcp_pick(in_bus, LCP_D2_BASE, cfg.d2_sel);
   assign cond.d1        = lcp_pick(in_bus, LCP_D1_BASE, cfg.d1_sel);

endmodule : lcp_cond

// [hdl/lcp_pkg.sv]
// Summary of operation
// - The final cell output is inverted when the output invert bit (bit 7) is set and passes unchanged otherwise; the bit is readable and writable and resets to zero.
// - Each gate output is inverted before the logic function when its invert bit is set, gate four on bit 3 down to gate one on bit 0.
// - Unimplemented bit positions read as zero, namely bits 6 to 4 of the polarity control register and bits 7 and 3 of the select register.
// - The data channel 2 source selector sits in bits 6 to 4 of the select register and is readable and writable.
// - Selector values 111, 110 and 101 route input bus lines 11, 10 and 9 to data channel 2.
// - Selector values 100 down to 000 route input bus lines 8 down to 4 to data channel 2.
// - The data channel 1 selector in bits 2 to 0 routes input bus line n to data channel 1 for value n.
// - The output invert is applied before the cell output reaches status readback, pins and other peripherals.
package lcp_pkg;

   localparam logic [31:0] LCP_POL_OFFS  = 32'h0000_0000;
   localparam logic [31:0] LCP_SEL_OFFS  = 32'h0000_0004;
   localparam logic [31:0] LCP_STAT_OFFS = 32'h0000_0008;

   localparam int          LCP_OUT_INV_BIT = 7;
   localparam int          LCP_GATE_LSB    = 0;
   localparam int          LCP_D2_LSB      = 4;
   localparam int          LCP_D1_LSB      = 0;
   localparam int          LCP_IN_W        = 16;
   localparam logic [3:0]  LCP_D2_BASE     = 4'h4;
   localparam logic [3:0]  LCP_D1_BASE     = 4'h0;

   localparam logic        LCP_OUT_INV_RST = 1'b0;
   localparam logic [3:0]  LCP_GATE_RST    = 4'h0;
   localparam logic [2:0]  LCP_SEL_RST     = 3'h0;

   localparam logic [1:0]  LCP_HTRANS_NONSEQ = 2'h2;
   localparam logic        LCP_HRESP_OKAY    = 1'b0;

   typedef struct packed {
      logic       out_inv;
      logic [3:0] gate_inv;
      logic [2:0] d2_sel;
      logic [2:0] d1_sel;
   } lcp_cfg_t;

   typedef struct packed {
      logic [3:0] gates;
      logic       final_out;
      logic       d1;
      logic       d2;
   } lcp_cond_t;

   // Picks one input bus line from a base and a 3-bit selector
   function automatic logic lcp_pick(input logic [LCP_IN_W-1:0] bus,
                                     input logic [3:0]          base,
                                     input logic [2:0]          sel);
      logic [3:0] idx;
      idx = base + {1'b0, sel};
      return bus[idx];
   endfunction : lcp_pick

   function automatic logic [31:0] lcp_pol_word(input lcp_cfg_t c);
      return {24'h00_0000, c.out_inv, 3'h0, c.gate_inv};
   endfunction : lcp_pol_word

   function automatic logic [31:0] lcp_sel_word(input lcp_cfg_t c);
      return {24'h00_0000, 1'b0, c.d2_sel, 1'b0, c.d1_sel};
   endfunction : lcp_sel_word

endpackage : lcp_pkg

// [hdl/lcp_top.sv]
module lcp_top (
   input  wire logic                         hclk,
   input  wire logic                         hresetn,
   input  wire logic                         ce,
   input  wire logic                         hsel,
   input  wire logic [31:0]                  haddr,
   input  wire logic [1:0]                   htrans,
   input  wire logic                         hwrite,
   input  wire logic [2:0]                   hsize,
   input  wire logic [31:0]                  hwdata,
   input  wire logic                         hready,
   output      logic [31:0]                  hrdata,
   output      logic                         hreadyout,
   output      logic                         hresp,
   input  wire logic [lcp_pkg::LCP_IN_W-1:0] cell_input_bus,
   input  wire logic [3:0]                   gate_raw,
   input  wire logic                         logic_raw,
   output      logic [3:0]                   gate_conditioned,
   output      logic                         cell_final_output,
   output      logic                         data_channel_1,
   output      logic                         data_channel_2
);
   import lcp_pkg::*;

   logic [LCP_IN_W-1:0] in_sync1_reg;
   logic [LCP_IN_W-1:0] in_sync2_reg;
   lcp_cfg_t            cfg_reg;
   lcp_cfg_t            cfg_next;
   lcp_cond_t           cond;
   lcp_cond_t           cond_reg;
   logic                wr_pend_reg;
   logic [31:0]         wr_addr_reg;
   logic [31:0]         hrdata_reg;

   // Bus decode
   wire addr_phase = hsel & hready & (htrans == LCP_HTRANS_NONSEQ);
   wire rd_take    = addr_phase & ~hwrite;
   wire wr_pol     = wr_pend_reg & (wr_addr_reg == LCP_POL_OFFS);
   wire wr_sel     = wr_pend_reg & (wr_addr_reg == LCP_SEL_OFFS);
   wire hit_pol    = (haddr == LCP_POL_OFFS);
   wire hit_sel    = (haddr == LCP_SEL_OFFS);
   wire hit_stat   = (haddr == LCP_STAT_OFFS);

   // Next configuration from a completing write
   assign cfg_next.out_inv  = wr_pol ? hwdata[LCP_OUT_INV_BIT] : cfg_reg.out_inv;
   assign cfg_next.gate_inv = wr_pol ? hwdata[LCP_GATE_LSB+:4] : cfg_reg.gate_inv;
   assign cfg_next.d2_sel   = wr_sel ? hwdata[LCP_D2_LSB+:3] : cfg_reg.d2_sel;
   assign cfg_next.d1_sel   = wr_sel ? hwdata[LCP_D1_LSB+:3] : cfg_reg.d1_sel;

   // Read mux; status shows the registered, inverted cell output
   wire [31:0] stat_word = {24'h00_0000, cond_reg.gates, 1'b0,
                            cond_reg.d2, cond_reg.d1, cond_reg.final_out};
   wire [31:0] rd_word   = hit_pol  ? lcp_pol_word(cfg_next) :
                           hit_sel  ? lcp_sel_word(cfg_next) :
                           hit_stat ? stat_word : 32'h0000_0000;

   lcp_cond u_cond (
      .cfg       (cfg_reg),
      .in_bus    (in_sync2_reg),
      .gate_raw  (gate_raw),
      .logic_raw (logic_raw),
      .cond      (cond)
   );

   // Pin synchroniser
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         in_sync1_reg <= 16'h0000;
         in_sync2_reg <= 16'h0000;
      end else if (ce) begin
         in_sync1_reg <= cell_input_bus;
         in_sync2_reg <= in_sync1_reg;
      end
   end

   // Configuration registers
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cfg_reg.out_inv  <= LCP_OUT_INV_RST;
         cfg_reg.gate_inv <= LCP_GATE_RST;
         cfg_reg.d2_sel   <= LCP_SEL_RST;
         cfg_reg.d1_sel   <= LCP_SEL_RST;
      end else if (ce) begin
         cfg_reg <= cfg_next;
      end
   end

   // Conditioned outputs
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cond_reg <= '0;
      end else if (ce) begin
         cond_reg <= cond;
      end
   end

   // Bus phases
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_reg <= 1'b0;
         wr_addr_reg <= 32'h0000_0000;
         hrdata_reg  <= 32'h0000_0000;
      end else if (ce) begin
         wr_pend_reg <= addr_phase & hwrite;
         wr_addr_reg <= haddr;
         hrdata_reg  <= rd_take ? rd_word : 32'h0000_0000;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hreadyout <= 1'b1;
         hresp     <= LCP_HRESP_OKAY;
      end else begin
         hreadyout <= 1'b1;
         hresp     <= LCP_HRESP_OKAY;
      end
   end

   assign hrdata            = hrdata_reg;
   assign gate_conditioned  = cond_reg.gates;
   assign cell_final_output = cond_reg.final_out;
   assign data_channel_1    = cond_reg.d1;
   assign data_channel_2    = cond_reg.d2;

   // Checks
   property p_out_inv;
      @(posedge hclk) disable iff (!hresetn)
      ($past(ce) && $past(hresetn))
         |-> cell_final_output == ($past(logic_raw) ^ $past(cfg_reg.out_inv));
   endproperty
   a_out_inv: assert property (p_out_inv)
      else $error("cell output polarity wrong");

   property p_gate_inv;
      @(posedge hclk) disable iff (!hresetn)
      ($past(ce) && $past(hresetn))
         |-> gate_conditioned == ($past(gate_raw) ^ $past(cfg_reg.gate_inv));
   endproperty
   a_gate_inv: assert property (p_gate_inv)
      else $error("gate polarity wrong");

   property p_pol_reserved;
      @(posedge hclk) disable iff (!hresetn)
      (ce && rd_take && hit_pol) |=> (hrdata[31:8] == 24'h00_0000) && (hrdata[6:4] == 3'h0);
   endproperty
   a_pol_reserved: assert property (p_pol_reserved)
      else $error("polarity reserved bits not zero");

   property p_sel_reserved;
      @(posedge hclk) disable iff (!hresetn)
      (ce && rd_take && hit_sel) |=> (hrdata[31:7] == 25'h000_0000) && !hrdata[3];
   endproperty
   a_sel_reserved: assert property (p_sel_reserved)
      else $error("select reserved bits not zero");

   property p_d2_write;
      @(posedge hclk) disable iff (!hresetn)
      (ce && wr_sel) |=> cfg_reg.d2_sel == $past(hwdata[6:4]);
   endproperty
   a_d2_write: assert property (p_d2_write)
      else $error("channel 2 selector not stored");

   property p_d2_store;
      @(posedge hclk) disable iff (!hresetn)
      (ce && wr_sel) ##1 (ce && rd_take && hit_sel) |=> hrdata[6:4] == $past(hwdata[6:4], 2);
   endproperty
   a_d2_store: assert property (p_d2_store)
      else $error("channel 2 selector readback wrong");

   property p_d2_high;
      @(posedge hclk) disable iff (!hresetn)
      ($past(ce) && $past(cfg_reg.d2_sel) == 3'h7) |-> data_channel_2 == $past(in_sync2_reg[11]);
   endproperty
   a_d2_high: assert property (p_d2_high)
      else $error("channel 2 not from line 11");

   property p_d2_mid;
      @(posedge hclk) disable iff (!hresetn)
      ($past(ce) && $past(cfg_reg.d2_sel) == 3'h5) |-> data_channel_2 == $past(in_sync2_reg[9]);
   endproperty
   a_d2_mid: assert property (p_d2_mid)
      else $error("channel 2 not from line 9");

   property p_d2_low;
      @(posedge hclk) disable iff (!hresetn)
      ($past(ce) && $past(cfg_reg.d2_sel) == 3'h0) |-> data_channel_2 == $past(in_sync2_reg[4]);
   endproperty
   a_d2_low: assert property (p_d2_low)
      else $error("channel 2 not from line 4");

   property p_d2_ten;
      @(posedge hclk) disable iff (!hresetn)
      ($past(ce) && $past(cfg_reg.d2_sel) == 3'h6) |-> data_channel_2 == $past(in_sync2_reg[10]);
   endproperty
   a_d2_ten: assert property (p_d2_ten)
      else $error("channel 2 not from line 10");

   property p_d2_eight;
      @(posedge hclk) disable iff (!hresetn)
      ($past(ce) && $past(cfg_reg.d2_sel) == 3'h4) |-> data_channel_2 == $past(in_sync2_reg[8]);
   endproperty
   a_d2_eight: assert property (p_d2_eight)
      else $error("channel 2 not from line 8");

   property p_d1_sel;
      @(posedge hclk) disable iff (!hresetn)
      $past(ce) |-> data_channel_1 == $past(in_sync2_reg[cfg_reg.d1_sel]);
   endproperty
   a_d1_sel: assert property (p_d1_sel)
      else $error("channel 1 line wrong");

   property p_status;
      @(posedge hclk) disable iff (!hresetn)
      (ce && rd_take && hit_stat) |=> hrdata[0] == $past(cell_final_output);
   endproperty
   a_status: assert property (p_status)
      else $error("status shows wrong cell output");

   property p_flip;
      @(posedge hclk) disable iff (!hresetn)
      (ce && wr_pol && (hwdata[7] != cfg_reg.out_inv)) ##1 (ce && $stable(logic_raw))
         |=> cell_final_output != $past(cell_final_output);
   endproperty
   a_flip: assert property (p_flip)
      else $error("invert change did not flip output");

endmodule : lcp_top

// [tb/lcp_src.sv]
module lcp_src (
   input  wire logic                         hclk,
   input  wire logic [lcp_pkg::LCP_IN_W-1:0] set_bus,
   input  wire logic [3:0]                   set_gate,
   input  wire logic                         set_logic,
   output      logic [lcp_pkg::LCP_IN_W-1:0] src_bus,
   output      logic [3:0]                   src_gate,
   output      logic                         src_logic
);
   timeunit 1ns;
   timeprecision 1ps;
   import lcp_pkg::*;
   // Sources update on the clock, as peripherals would
   always_ff @(posedge hclk) begin
      src_bus   <= set_bus;
      src_gate  <= set_gate;
      src_logic <= set_logic;
   end
endmodule : lcp_src

// [tb/tb_top.sv]
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import lcp_pkg::*;
   typedef struct packed {
      logic [7:0] pol, sel;
      logic [15:0] bus;
      logic [3:0] gate;
      logic lg;
      logic [31:0] stat;
   } lcp_row_t;
   logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, lg_set = 0, lg_src, fo, d1, d2, hresp, hrdy;
   logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
   logic [1:0] htrans = 0;
   logic ce = 1;
   logic [15:0] bus_set = 0, bus_src;
   logic [3:0] gate_set = 0, gate_src, gc;
   int miscompares = 0, cmp_count = 0, cyc = 0;
   lcp_row_t rows [16];
   always #4 hclk = ~hclk;
   lcp_src src (.hclk(hclk), .set_bus(bus_set), .set_gate(gate_set), .set_logic(lg_set),
                .src_bus(bus_src), .src_gate(gate_src), .src_logic(lg_src));
   lcp_top dut (.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr),
                .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
                .hready(hrdy), .hrdata(hrdata), .hreadyout(hrdy), .hresp(hresp),
                .cell_input_bus(bus_src), .gate_raw(gate_src), .logic_raw(lg_src),
                .gate_conditioned(gc), .cell_final_output(fo),
                .data_channel_1(d1), .data_channel_2(d2));
   task automatic end_of_test();
      $display("Counts: %0d compares, %0d mismatches", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : end_of_test
   always @(posedge hclk) begin
      cyc <= cyc + 1;
      if (cyc == 6000) begin
         miscompares = miscompares + 1;
         end_of_test();
      end
   end
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      cmp_count++;
      if (g !== e) begin
         miscompares++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic xfer(input logic [31:0] a, input logic w, input logic [31:0] d);
      hsel <= 1'b1; haddr <= a; hwrite <= w; htrans <= LCP_HTRANS_NONSEQ;
      do @(posedge hclk); while (hrdy !== 1'b1);
      htrans <= 2'h0; hwdata <= d;
      do @(posedge hclk); while (hrdy !== 1'b1);
      rd = hrdata;
      chk("hresp", 32'h0, {31'h0, hresp});
   endtask : xfer
   task automatic rchk(input string nm, input logic [31:0] a, input logic [31:0] e);
      xfer(a, 1'b0, 32'h0);
      chk(nm, e, rd);
   endtask : rchk
   initial begin
      for (int i = 0; i < 16; i++) begin
         logic [2:0] k;
         logic [15:0] oh, b;
         k = i[2:0];
         oh = (16'h1 << (4 + k)) | (16'h1 << (7 - k));
         b = i[3] ? ~oh : oh;
         rows[i] = '{pol: {i[0], 3'h0, 4'(i * 5)}, sel: {1'b0, k, 1'b0, ~k}, bus: b,
                     gate: 4'(i), lg: i[1], stat: 32'h0};
         rows[i].stat = {24'h0, 4'(i) ^ 4'(i * 5), 1'b0, b[4 + k], b[7 - k], i[1] ^ i[0]};
      end
      repeat (8) @(posedge hclk);
      hresetn <= 1'b1;
      rchk("pol reset", LCP_POL_OFFS, 32'h0);
      rchk("sel reset", LCP_SEL_OFFS, 32'h0);
      rchk("stat reset", LCP_STAT_OFFS, 32'h0);
      $display("Test reset done");
      foreach (rows[i]) begin
         xfer(LCP_POL_OFFS, 1'b1, {24'h0, rows[i].pol});
         xfer(LCP_SEL_OFFS, 1'b1, {24'h0, rows[i].sel});
         bus_set <= rows[i].bus; gate_set <= rows[i].gate; lg_set <= rows[i].lg;
         repeat (6) @(posedge hclk);
         chk("gate_conditioned", {28'h0, rows[i].stat[7:4]}, {28'h0, gc});
         chk("cell_final_output", {31'h0, rows[i].stat[0]}, {31'h0, fo});
         chk("data_channel_1", {31'h0, rows[i].stat[1]}, {31'h0, d1});
         chk("data_channel_2", {31'h0, rows[i].stat[2]}, {31'h0, d2});
         rchk("status", LCP_STAT_OFFS, rows[i].stat);
         rchk("sel readback", LCP_SEL_OFFS, {24'h0, rows[i].sel});
      end
      $display("Test table done");
      xfer(LCP_POL_OFFS, 1'b1, 32'hFFFF_FFFF);
      rchk("pol unimpl", LCP_POL_OFFS, 32'h0000_008F);
      xfer(LCP_SEL_OFFS, 1'b1, 32'hFFFF_FFFF);
      rchk("sel unimpl", LCP_SEL_OFFS, 32'h0000_0077);
      xfer(32'h0000_000C, 1'b1, 32'hFFFF_FFFF);
      rchk("unmapped", 32'h0000_000C, 32'h0);
      $display("Test masks done");
      lg_set <= 1'b1;
      xfer(LCP_POL_OFFS, 1'b1, 32'h0000_0000);
      repeat (4) @(posedge hclk);
      chk("invert off", 32'h1, {31'h0, fo});
      xfer(LCP_POL_OFFS, 1'b1, 32'h0000_0080);
      repeat (2) @(posedge hclk);
      chk("invert on", 32'h0, {31'h0, fo});
      $display("Test invert done");
      gate_set <= 4'hA;
      hresetn <= 1'b0;
      repeat (2) @(posedge hclk);
      chk("fo in reset", 32'h0, {31'h0, fo});
      chk("hreadyout in reset", 32'h1, {31'h0, hrdy});
      hresetn <= 1'b1;
      rchk("pol after reset", LCP_POL_OFFS, 32'h0);
      rchk("sel after reset", LCP_SEL_OFFS, 32'h0);
      chk("gate after reset", 32'hA, {28'h0, gc});
      $display("Test mid-run reset done");
      ce <= 1'b0;
      gate_set <= 4'h5;
      lg_set <= 1'b0;
      xfer(LCP_POL_OFFS, 1'b1, 32'h0000_008F);
      repeat (3) @(posedge hclk);
      chk("gate frozen", 32'hA, {28'h0, gc});
      chk("fo frozen", 32'h1, {31'h0, fo});
      ce <= 1'b1;
      rchk("pol frozen", LCP_POL_OFFS, 32'h0);
      $display("Test clock enable done");
      end_of_test();
   end
endmodule : tb_top
